//--- pkg/uplp_pkg.sv
/*
 * Constants, state codes and timing counts shared by the link-facing pin logic of the transceiver.
 * Assumes a single 100 MHz core clock that stands for the interface clock domain.
 */
// Overview of operation
// - Output-clock mode sources the interface clock; all bus outputs change on rising edges.
// - Clock pin held high after reset selects input-clock mode.
// - During link transmit, next is high when the byte on the bus is taken.
// - Eight-bit two-way data bus shared for commands, data and status.
// - Three frequency straps read together; all must be high in input-clock mode.
// - External supply enable output is low after reset, then follows the enable request once straps are read.
// - Direction high owns the bus from a waiting byte until the byte marked last is sent; low otherwise, watching commands.
// - Chip reset low for 1 us then released resets all state.
package uplp_pkg;

	// ************************************************************
	// Widths and strap values
	// ************************************************************
	localparam int          DATA_W         = 8;
	localparam int          STRAP_W        = 3;
	localparam int          LEVEL_W        = 2;
	localparam logic [2:0]  STRAP_ALL_HIGH = 3'h7;
	localparam logic [7:0]  BUS_IDLE       = 8'h00;
	localparam logic [2:0]  STRAP_RST      = 3'h0;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int          CORE_CLK_PS    = 10000;
	localparam int          IFC_CLK_MHZ    = 60;
	localparam int          RESET_MIN_US   = 1;
	localparam int          RESET_MIN_PS   = RESET_MIN_US * 1000000;
	localparam int          RESET_MIN_CYC  = (RESET_MIN_PS + CORE_CLK_PS - 1) / CORE_CLK_PS;
	localparam int          RST_CNT_W      = 8;

	// ************************************************************
	// Bus ownership states
	// ************************************************************
	typedef enum logic [5:0] {
		ST_HALT    = 6'h01,
		ST_IDLE    = 6'h02,
		ST_RECV    = 6'h04,
		ST_TURN_UP = 6'h08,
		ST_SEND    = 6'h10,
		ST_TURN_DN = 6'h20
	} uplp_state_e;

endpackage

//--- core/uplp_buf2.sv
/*
 * Two-entry buffer with valid and ready on both sides; all outputs come from flip-flops.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module uplp_buf2 #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic               core_clk,
	input  wire logic               rstn,
	// Filling side
	input  wire logic               in_valid,
	input  wire logic [WIDTH-1:0]   in_data,
	output logic                    in_ready,
	// Draining side
	output logic                    out_valid,
	output logic [WIDTH-1:0]        out_data,
	input  wire logic               out_ready,
	// Fill level
	output logic [1:0]              level
);
	logic             head_v_reg, head_v_next;
	logic [WIDTH-1:0] head_d_reg, head_d_next;
	logic             tail_v_reg, tail_v_next;
	logic [WIDTH-1:0] tail_d_reg, tail_d_next;
	logic             push;
	logic             pop;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		push        = in_valid && !tail_v_reg;
		pop         = head_v_reg && out_ready;
		head_v_next = head_v_reg;
		head_d_next = head_d_reg;
		tail_v_next = tail_v_reg;
		tail_d_next = tail_d_reg;
		if (pop) begin
			if (tail_v_reg) begin
				head_d_next = tail_d_reg;
				tail_v_next = 1'b0;
			end else begin
				head_v_next = push;
				head_d_next = in_data;
			end
		end else if (push) begin
			if (head_v_reg) begin
				tail_v_next = 1'b1;
				tail_d_next = in_data;
			end else begin
				head_v_next = 1'b1;
				head_d_next = in_data;
			end
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			head_v_reg <= 1'b0;
			head_d_reg <= '0;
			tail_v_reg <= 1'b0;
			tail_d_reg <= '0;
		end else begin
			head_v_reg <= head_v_next;
			head_d_reg <= head_d_next;
			tail_v_reg <= tail_v_next;
			tail_d_reg <= tail_d_next;
		end
	end

	assign in_ready  = !tail_v_reg;
	assign out_valid = head_v_reg;
	assign out_data  = head_d_reg;
	assign level     = {head_v_reg && tail_v_reg, head_v_reg != tail_v_reg};

endmodule // uplp_buf2

//--- core/uplp_top.sv
/*
 * Link-facing pin logic of the transceiver: clock pin, data bus, direction, next, stop, straps and
 * supply enable. Assumes core_clk is the interface clock and the bench resolves the two-way pins.
 */
`timescale 1ns/1ps
module uplp_top (
	// Clock and reset
	input  wire logic                         core_clk,
	input  wire logic                         rstn,
	// Chip reset pin
	input  wire logic                         chip_reset_n,
	// Interface clock pin
	input  wire logic                         interface_clock_in,
	output logic                              interface_clock_out,
	output logic                              interface_clock_oe,
	// Frequency straps
	input  wire logic [uplp_pkg::STRAP_W-1:0] ref_freq_strap,
	// Link bus
	input  wire logic [uplp_pkg::DATA_W-1:0]  data_in,
	output logic      [uplp_pkg::DATA_W-1:0]  data_out,
	output logic                              data_oe,
	output logic                              dir,
	output logic                              nxt,
	input  wire logic                         stp,
	// Received stream to the core
	output logic                              rx_valid,
	output logic      [uplp_pkg::DATA_W-1:0]  rx_data,
	input  wire logic                         rx_ready,
	output logic                              rx_stream_end,
	// Stream from the core to the link
	input  wire logic                         tx_valid,
	input  wire logic [uplp_pkg::DATA_W-1:0]  tx_data,
	input  wire logic                         tx_last,
	output logic                              tx_ready,
	// Supply switch and mode status
	input  wire logic                         vbus_enable_req,
	output logic                              vbus_supply_enable,
	output logic                              input_clock_mode,
	output logic      [uplp_pkg::STRAP_W-1:0] ref_freq_sel,
	output logic                              strap_mismatch
);
	import uplp_pkg::*;

	// ************************************************************
	// Synchronisers for pins
	// ************************************************************
	logic [STRAP_W+1:0] sync1_reg;
	logic [STRAP_W+1:0] sync2_reg;
	logic               pin_reset_n;
	logic               pin_clock;
	logic [STRAP_W-1:0] pin_strap;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= {chip_reset_n, interface_clock_in, ref_freq_strap};
			sync2_reg <= sync1_reg;
		end
	end

	assign pin_reset_n = sync2_reg[STRAP_W+1];
	assign pin_clock   = sync2_reg[STRAP_W];
	assign pin_strap   = sync2_reg[STRAP_W-1:0];

	// ************************************************************
	// Chip reset, straps, clock and supply enable
	// ************************************************************
	logic                 hold;
	logic                 soft_clr_reg, soft_clr_next;
	logic [RST_CNT_W-1:0] rst_cnt_reg, rst_cnt_next;
	logic                 strap_done_reg, strap_done_next;
	logic                 in_mode_reg, in_mode_next;
	logic [STRAP_W-1:0]   sel_reg, sel_next;
	logic                 mismatch_reg, mismatch_next;
	logic                 clk_o_reg, clk_o_next;
	logic                 clk_oe_reg, clk_oe_next;
	logic                 vbus_reg, vbus_next;
	logic                 buf_rstn;

	assign hold = !pin_reset_n;

	always_comb begin
		soft_clr_next   = 1'b0;
		rst_cnt_next    = rst_cnt_reg;
		strap_done_next = strap_done_reg;
		in_mode_next    = in_mode_reg;
		sel_next        = sel_reg;
		mismatch_next   = mismatch_reg;
		clk_o_next      = 1'b0;
		clk_oe_next     = 1'b0;
		vbus_next       = vbus_reg;
		if (hold) begin
			if (rst_cnt_reg != RST_CNT_W'(RESET_MIN_CYC)) begin
				rst_cnt_next = rst_cnt_reg + 1'b1;
			end
			vbus_next = 1'b0;
		end else if (rst_cnt_reg == RST_CNT_W'(RESET_MIN_CYC)) begin
			rst_cnt_next    = '0;
			soft_clr_next   = 1'b1;
			strap_done_next = 1'b0;
			vbus_next       = 1'b0;
		end else begin
			rst_cnt_next = '0;
			if (!strap_done_reg && !soft_clr_reg) begin
				strap_done_next = 1'b1;
				in_mode_next    = pin_clock;
				sel_next        = pin_strap;
				mismatch_next   = pin_clock && (pin_strap != STRAP_ALL_HIGH);
			end
			if (strap_done_reg && !in_mode_reg) begin
				clk_oe_next = 1'b1;
				clk_o_next  = !clk_o_reg;
			end
			if (strap_done_reg) begin
				vbus_next = vbus_enable_req;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			soft_clr_reg   <= 1'b0;
			rst_cnt_reg    <= '0;
			strap_done_reg <= 1'b0;
			in_mode_reg    <= 1'b0;
			sel_reg        <= STRAP_RST;
			mismatch_reg   <= 1'b0;
			clk_o_reg      <= 1'b0;
			clk_oe_reg     <= 1'b0;
			vbus_reg       <= 1'b0;
		end else begin
			soft_clr_reg   <= soft_clr_next;
			rst_cnt_reg    <= rst_cnt_next;
			strap_done_reg <= strap_done_next;
			in_mode_reg    <= in_mode_next;
			sel_reg        <= sel_next;
			mismatch_reg   <= mismatch_next;
			clk_o_reg      <= clk_o_next;
			clk_oe_reg     <= clk_oe_next;
			vbus_reg       <= vbus_next;
		end
	end

	assign buf_rstn = rstn && !soft_clr_reg;

	// ************************************************************
	// Buffers in both data paths
	// ************************************************************
	logic              rx_push;
	logic [1:0]        rx_level;
	logic              rx_in_ready;
	logic              tx_out_valid;
	logic [DATA_W:0]   tx_out_data;
	logic              tx_pop;

	uplp_buf2 #(.WIDTH(DATA_W)) u_rx_buf (
		.core_clk  (core_clk),
		.rstn      (buf_rstn),
		.in_valid  (rx_push),
		.in_data   (data_in),
		.in_ready  (rx_in_ready),
		.out_valid (rx_valid),
		.out_data  (rx_data),
		.out_ready (rx_ready),
		.level     (rx_level)
	);

	uplp_buf2 #(.WIDTH(DATA_W + 1)) u_tx_buf (
		.core_clk  (core_clk),
		.rstn      (buf_rstn),
		.in_valid  (tx_valid),
		.in_data   ({tx_last, tx_data}),
		.in_ready  (tx_ready),
		.out_valid (tx_out_valid),
		.out_data  (tx_out_data),
		.out_ready (tx_pop),
		.level     ()
	);

	// ************************************************************
	// Bus ownership
	// ************************************************************
	uplp_state_e       st_reg, st_next;
	logic [DATA_W-1:0] dout_reg, dout_next;
	logic              doe_reg, doe_next;
	logic              dir_reg, dir_next;
	logic              nxt_reg, nxt_next;
	logic              last_reg, last_next;
	logic              end_reg, end_next;
	logic [2:0]        fill;

	always_comb begin
		st_next   = st_reg;
		dout_next = BUS_IDLE;
		doe_next  = 1'b0;
		dir_next  = 1'b0;
		nxt_next  = 1'b0;
		last_next = last_reg;
		end_next  = 1'b0;
		tx_pop    = 1'b0;
		rx_push   = (st_reg == ST_RECV) && nxt_reg && !stp && rx_in_ready;
		fill      = {1'b0, rx_level} + {2'b00, rx_push} - {2'b00, rx_valid && rx_ready};
		unique case (st_reg)
			ST_HALT: begin
				if (!hold && strap_done_reg) begin
					st_next = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (data_in != BUS_IDLE) begin
					st_next  = ST_RECV;
					nxt_next = fill < 3'h2;
				end else if (tx_out_valid && !stp) begin
					st_next  = ST_TURN_UP;
					dir_next = 1'b1;
				end
			end
			ST_RECV: begin
				if (stp) begin
					st_next  = ST_IDLE;
					end_next = 1'b1;
				end else begin
					nxt_next = fill < 3'h2;
				end
			end
			ST_TURN_UP: begin
				st_next   = ST_SEND;
				dir_next  = 1'b1;
				doe_next  = 1'b1;
				dout_next = tx_out_data[DATA_W-1:0];
				nxt_next  = 1'b1;
				tx_pop    = 1'b1;
				last_next = tx_out_data[DATA_W];
			end
			ST_SEND: begin
				if (last_reg) begin
					st_next = ST_TURN_DN;
				end else begin
					dir_next = 1'b1;
					doe_next = 1'b1;
					if (tx_out_valid) begin
						dout_next = tx_out_data[DATA_W-1:0];
						nxt_next  = 1'b1;
						tx_pop    = 1'b1;
						last_next = tx_out_data[DATA_W];
					end
				end
			end
			ST_TURN_DN: begin
				st_next   = ST_IDLE;
				last_next = 1'b0;
			end
			default: begin
				st_next = ST_HALT;
			end
		endcase
		if (hold || soft_clr_reg) begin
			st_next   = ST_HALT;
			dout_next = BUS_IDLE;
			doe_next  = 1'b0;
			dir_next  = 1'b0;
			nxt_next  = 1'b0;
			last_next = 1'b0;
			tx_pop    = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			st_reg   <= ST_HALT;
			dout_reg <= BUS_IDLE;
			doe_reg  <= 1'b0;
			dir_reg  <= 1'b0;
			nxt_reg  <= 1'b0;
			last_reg <= 1'b0;
			end_reg  <= 1'b0;
		end else begin
			st_reg   <= st_next;
			dout_reg <= dout_next;
			doe_reg  <= doe_next;
			dir_reg  <= dir_next;
			nxt_reg  <= nxt_next;
			last_reg <= last_next;
			end_reg  <= end_next;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign interface_clock_out = clk_o_reg;
	assign interface_clock_oe  = clk_oe_reg;
	assign data_out            = dout_reg;
	assign data_oe             = doe_reg;
	assign dir                 = dir_reg;
	assign nxt                 = nxt_reg;
	assign rx_stream_end       = end_reg;
	assign vbus_supply_enable  = vbus_reg;
	assign input_clock_mode    = in_mode_reg;
	assign ref_freq_sel        = sel_reg;
	assign strap_mismatch      = mismatch_reg;

endmodule // uplp_top

//--- verif/uplp_link_model.sv
/*
 * Link controller model: sends counted streams to the device and collects the bytes that it sends.
 * Assumes the device drives the bus only while dir is high; nothing pulls the bus when released.
 */
`timescale 1ns/1ps
module uplp_link_model (
	// Clock, reset and device pins
	input  wire logic       core_clk,
	input  wire logic       rstn,
	input  wire logic       dir,
	input  wire logic       nxt,
	input  wire logic       data_oe,
	input  wire logic [7:0] data_out,
	// Bench control
	input  wire logic       start,
	input  wire logic [7:0] len,
	// Link pins and observations
	output logic      [7:0] data_in,
	output logic            stp,
	output logic            busy,
	output logic            got_valid,
	output logic      [7:0] got_byte
);
	logic [7:0] k_reg;
	logic [7:0] last_reg;
	logic       dir_q;
	logic       link_drive;

	// The link keeps off the bus while dir is high and for one turnaround cycle after it falls.
	assign link_drive = !dir && !dir_q;
	assign data_in = data_oe ? data_out : link_drive ? (busy ? 8'h40 + k_reg : 8'h00) : ~last_reg;

	always_ff @(posedge core_clk) begin
		dir_q     <= dir;
		last_reg  <= data_in;
		stp       <= 1'b0;
		got_valid <= dir && nxt && data_oe;
		got_byte  <= data_out;
		if (!rstn) begin
			busy  <= 1'b0;
			k_reg <= 8'h00;
		end else if (start && !busy) begin
			busy  <= 1'b1;
			k_reg <= 8'h00;
		end else if (busy && nxt && link_drive) begin
			k_reg <= k_reg + 8'h01;
			if (k_reg + 8'h01 == len) begin
				busy <= 1'b0;
				stp  <= 1'b1;
			end
		end
	end
endmodule // uplp_link_model

//--- verif/uplp_top_assertions.sv
/*
 * Concurrent checks on the ports of the link-facing pin logic.
 * Assumes one clock, core_clk, and the synchronous active-low reset rstn.
 */
`timescale 1ns/1ps
module uplp_top_assertions (
	input  wire logic core_clk,
	input  wire logic rstn,
	input  wire logic chip_reset_n,
	input  wire logic interface_clock_out,
	input  wire logic interface_clock_oe,
	input  wire logic data_oe,
	input  wire logic dir,
	input  wire logic nxt,
	input  wire logic stp,
	input  wire logic rx_stream_end,
	input  wire logic vbus_enable_req,
	input  wire logic vbus_supply_enable,
	input  wire logic input_clock_mode
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	oe_needs_dir_a: assert property (data_oe |-> dir) else $error("bus driven without dir");
	turn_quiet_a: assert property ($changed(dir) |-> !data_oe) else $error("bus driven in turnaround");
	turn_no_next_a: assert property (nxt && !dir |-> !$past(dir)) else $error("next in turnaround");
	tx_next_data_a: assert property (dir && nxt |-> data_oe) else $error("next without data");
	stop_quiet_a: assert property (stp && !dir |=> !nxt) else $error("next after stop");
	end_cause_a: assert property (rx_stream_end |-> $past(stp)) else $error("end without stop");
	chip_halt_a: assert property (!chip_reset_n [*5] |-> !vbus_supply_enable && !data_oe && !dir && !nxt)
		else $error("outputs active in chip reset");
	clk_mode_a: assert property (input_clock_mode |-> !interface_clock_oe) else $error("clock pin driven");
	clk_toggle_a: assert property (interface_clock_oe && $past(interface_clock_oe)
		|-> interface_clock_out != $past(interface_clock_out)) else $error("clock not toggling");
	vbus_follow_a: assert property (vbus_supply_enable |-> $past(vbus_enable_req) && $past(chip_reset_n, 3))
		else $error("supply enable without request");

	cover property (nxt && !dir);
	cover property (dir && data_oe && nxt);
	cover property (rx_stream_end);
endmodule // uplp_top_assertions

bind uplp_top uplp_top_assertions uplp_top_assertions_i (.core_clk, .rstn, .chip_reset_n, .interface_clock_out,
	.interface_clock_oe, .data_oe, .dir, .nxt, .stp, .rx_stream_end, .vbus_enable_req, .vbus_supply_enable,
	.input_clock_mode);

//--- verif/uplp_top_tb.sv
/*
 * Self-checking bench for the link-facing pin logic with a link controller model on the bus.
 * Assumes the design resets synchronously and captures its straps after rstn and after each chip reset of at least 1 us.
 */
`timescale 1ns/1ps
module uplp_top_tb;
	import uplp_pkg::*;
	logic       core_clk = 1'b0, rstn = 1'b0, chip_reset_n = 1'b1, clk_strap = 1'b1, clk_pin;
	logic       rx_ready = 1'b1, tx_valid = 1'b0, tx_last = 1'b0, vbus_enable_req = 1'b0, start = 1'b0;
	logic       tx_full = 1'b0, interface_clock_out, interface_clock_oe, data_oe, dir, nxt, stp, rx_valid;
	logic       rx_stream_end, tx_ready, vbus_supply_enable, input_clock_mode, strap_mismatch, busy, got_valid;
	logic [2:0] ref_freq_strap = 3'h7, ref_freq_sel;
	logic [7:0] tx_data = 8'h00, len = 8'h00, data_in, data_out, rx_data, got_byte;
	logic [7:0] got_q [$];
	int         num_errors = 0, cmp_count = 0, cycles = 0;

	assign clk_pin = interface_clock_oe ? interface_clock_out : clk_strap;
	always #5 core_clk = ~core_clk;

	uplp_top uplp_top_i (.core_clk, .rstn, .chip_reset_n, .interface_clock_in(clk_pin), .interface_clock_out,
		.interface_clock_oe, .ref_freq_strap, .data_in, .data_out, .data_oe, .dir, .nxt, .stp, .rx_valid, .rx_data,
		.rx_ready, .rx_stream_end, .tx_valid, .tx_data, .tx_last, .tx_ready, .vbus_enable_req, .vbus_supply_enable,
		.input_clock_mode, .ref_freq_sel, .strap_mismatch);
	uplp_link_model uplp_link_model_i (.core_clk, .rstn, .dir, .nxt, .data_oe, .data_out, .start, .len, .data_in,
		.stp, .busy, .got_valid, .got_byte);

	always @(posedge core_clk) begin
		if (got_valid === 1'b1) got_q.push_back(got_byte);
		if (tx_valid && tx_ready === 1'b0) tx_full <= 1'b1;
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			end_of_test();
		end
	end

	task automatic chk(input logic ok, input string m);
		cmp_count++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask

	task automatic do_reset(input logic pin, input logic [2:0] s);
		@(negedge core_clk);
		rstn = 1'b0;
		clk_strap = pin;
		ref_freq_strap = s;
		repeat (12) @(negedge core_clk);
		rstn = 1'b1;
		repeat (8) @(negedge core_clk);
	endtask

	task automatic t_modes();
		logic [3:0] tbl [3] = '{4'hf, 4'hb, 4'h5};
		logic v;
		for (int i = 0; i < 3; i++) begin
			do_reset(tbl[i][3], tbl[i][2:0]);
			chk(input_clock_mode === tbl[i][3] && ref_freq_sel === tbl[i][2:0], "mode or strap capture");
			chk(strap_mismatch === (tbl[i][3] && tbl[i][2:0] != STRAP_ALL_HIGH), "strap check");
			chk(interface_clock_oe === !tbl[i][3] && vbus_supply_enable === 1'b0, "clock pin or supply");
			v = interface_clock_out;
			@(negedge core_clk);
			chk(interface_clock_oe !== 1'b1 || interface_clock_out === !v, "clock not toggling");
		end
	endtask

	task automatic t_rx(input logic [7:0] n, input logic stall);
		int got = 0;
		logic seen_end = 1'b0;
		rx_ready = !stall;
		len = n;
		start = 1'b1;
		@(negedge core_clk);
		start = 1'b0;
		if (stall) begin
			repeat (10) @(negedge core_clk);
			chk(nxt === 1'b0 && busy === 1'b1, "next with receive buffer full");
			rx_ready = 1'b1;
		end
		repeat (40) begin
			if (rx_valid === 1'b1 && rx_ready) begin
				chk(rx_data === 8'h40 + got[7:0], "received byte out of order");
				got++;
			end
			if (rx_stream_end === 1'b1) seen_end = 1'b1;
			@(negedge core_clk);
		end
		chk(got == n && seen_end, "stream length or end marker");
	endtask

	task automatic t_tx();
		logic [7:0] exp [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
		got_q.delete();
		for (int i = 0; i < 4; i++) begin
			tx_valid = 1'b1;
			tx_data = exp[i];
			tx_last = (i >= 2);
			do @(posedge core_clk); while (tx_ready !== 1'b1);
			@(negedge core_clk);
		end
		tx_valid = 1'b0;
		repeat (30) @(negedge core_clk);
		chk(tx_full && got_q.size() == 4, "send buffer never full or byte count");
		foreach (got_q[i]) chk(got_q[i] === exp[i], "byte to link");
	endtask

	task automatic t_vbus();
		vbus_enable_req = 1'b1;
		repeat (3) @(negedge core_clk);
		chk(vbus_supply_enable === 1'b1, "supply enable did not follow");
		chip_reset_n = 1'b0;
		ref_freq_strap = 3'h6;
		repeat (110) @(negedge core_clk);
		chk(vbus_supply_enable === 1'b0 && dir === 1'b0 && data_oe === 1'b0, "outputs active in reset");
		chip_reset_n = 1'b1;
		vbus_enable_req = 1'b0;
		repeat (8) @(negedge core_clk);
		chk(input_clock_mode === 1'b0 && ref_freq_sel === 3'h6, "straps after chip reset");
		chip_reset_n = 1'b0;
		ref_freq_strap = 3'h2;
		repeat (20) @(negedge core_clk);
		chip_reset_n = 1'b1;
		repeat (8) @(negedge core_clk);
		chk(ref_freq_sel === 3'h6 && interface_clock_oe === 1'b1, "short chip reset cleared state");
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		t_modes();
		t_rx(8'h01, 1'b0);
		t_rx(8'h02, 1'b0);
		t_rx(8'h05, 1'b1);
		t_tx();
		t_vbus();
		t_rx(8'h03, 1'b0);
		end_of_test();
	end
endmodule // uplp_top_tb
